// [sim/psbs_host_model.sv]
// --------------------------------------------------------------
// bus master model: drives the synchronous pins after each edge
// --------------------------------------------------------------
module psbs_host_model (
  input wire logic sys_clk, // port clock
  output logic [5:0] addr, // word address
  output logic proc_addr_strobe_n, // processor strobe
  output logic ctrl_addr_strobe_n, // controller strobe
  output logic burst_advance_n, // burst advance
  output logic pipe_chip_en_n, // select, low
  output logic depth_chip_en_hi, // select, high
  output logic depth_chip_en_n, // select, low
  output logic [3:0] byte_lane_sel_n, // lane selects
  output logic byte_wr_en_n, // byte write enable
  output logic all_bytes_wr_n, // global write
  output logic [35:0] dq_in // write data
);
  timeunit 1ns;
  timeprecision 100ps;

  // idle bus at time zero
  initial
  begin
    addr = 6'h2A;
    dq_in = 36'h5_A5A5_A5A5;
    pipe_chip_en_n = 1'b0;
    depth_chip_en_hi = 1'b1;
    depth_chip_en_n = 1'b0;
    idle_ctl();
  end

  task automatic idle_ctl();
    proc_addr_strobe_n = 1'b1;
    ctrl_addr_strobe_n = 1'b1;
    burst_advance_n = 1'b1;
    {all_bytes_wr_n, byte_wr_en_n, byte_lane_sel_n} = 6'h3F;
  endtask

  // let one edge pass, then move by the fixed skew
  task automatic step();
    @(posedge sys_clk);
    #1;
  endtask

  // strobed first beat; address and selects held through the taking edge
  task automatic start(input logic use_ctrl, input logic sel, input logic [5:0] a, input logic [5:0] ctl,
                       input logic [35:0] d);
    addr = a;
    proc_addr_strobe_n = use_ctrl;
    ctrl_addr_strobe_n = !use_ctrl;
    depth_chip_en_hi = sel;
    burst_advance_n = 1'b1;
    {all_bytes_wr_n, byte_wr_en_n, byte_lane_sel_n} = ctl;
    dq_in = d;
    step();
  endtask

  // later beat: no strobe, advance low, address no longer meaningful
  task automatic next_beat(input logic [5:0] ctl, input logic [35:0] d);
    proc_addr_strobe_n = 1'b1;
    ctrl_addr_strobe_n = 1'b1;
    burst_advance_n = 1'b0;
    {all_bytes_wr_n, byte_wr_en_n, byte_lane_sel_n} = ctl;
    dq_in = d;
    addr = ~addr;
    step();
  endtask

  // released lines flip so a stale value is never read as good
  task automatic release_bus();
    idle_ctl();
    addr = ~addr;
    dq_in = ~dq_in;
  endtask
endmodule // psbs_host_model

// [sim/test_pipelined_sync_burst_sram_port.sv]
// --------------------------------------------------------------
// self-checking bench for the burst memory port
// --------------------------------------------------------------
module test_pipelined_sync_burst_sram_port;
  timeunit 1ns;
  timeprecision 100ps;
  logic sys_clk, rst_n, out_en_n, sleep_req, linear_burst_sel, rd_ready, lin;
  logic proc_addr_strobe_n, ctrl_addr_strobe_n, burst_advance_n, pipe_chip_en_n, depth_chip_en_hi;
  logic depth_chip_en_n, byte_wr_en_n, all_bytes_wr_n, dq_oe, rd_valid;
  logic [5:0] addr;
  logic [3:0] byte_lane_sel_n;
  logic [35:0] dq_in, dq_out;
  logic [35:0] exp_mem [64];
  int mismatches = 0;
  int n_checks = 0;

  psbs_sram_port #(.AW(6), .DW(36)) i_dut (.sys_clk(sys_clk), .rst_n(rst_n), .addr(addr),
    .proc_addr_strobe_n(proc_addr_strobe_n), .ctrl_addr_strobe_n(ctrl_addr_strobe_n),
    .burst_advance_n(burst_advance_n), .pipe_chip_en_n(pipe_chip_en_n), .depth_chip_en_hi(depth_chip_en_hi),
    .depth_chip_en_n(depth_chip_en_n), .byte_lane_sel_n(byte_lane_sel_n), .byte_wr_en_n(byte_wr_en_n),
    .all_bytes_wr_n(all_bytes_wr_n), .out_en_n(out_en_n), .sleep_req(sleep_req),
    .linear_burst_sel(linear_burst_sel), .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe),
    .rd_valid(rd_valid), .rd_ready(rd_ready));
  psbs_host_model i_host (.sys_clk(sys_clk), .addr(addr), .proc_addr_strobe_n(proc_addr_strobe_n),
    .ctrl_addr_strobe_n(ctrl_addr_strobe_n), .burst_advance_n(burst_advance_n),
    .pipe_chip_en_n(pipe_chip_en_n), .depth_chip_en_hi(depth_chip_en_hi), .depth_chip_en_n(depth_chip_en_n),
    .byte_lane_sel_n(byte_lane_sel_n), .byte_wr_en_n(byte_wr_en_n), .all_bytes_wr_n(all_bytes_wr_n),
    .dq_in(dq_in));

  task automatic chk(input logic [35:0] got, input logic [35:0] want, input string what);
    n_checks++;
    if (got !== want)
    begin
      mismatches++;
      $display("BAD %0t %s got %h want %h", $time, what, got, want);
    end
  endtask

  // address of beat i from the seed, in the current order
  function automatic logic [5:0] beat_addr(input logic [5:0] a, input int i);
    logic [1:0] k;
    k = lin ? a[1:0] + 2'(i) : a[1:0] ^ 2'(i);
    return {a[5:2], k};
  endfunction

  // ctl packs global write, byte enable and four lane selects
  task automatic wr_burst(input logic [5:0] a, input logic [5:0] ctl, input logic [35:0] d, input int beats);
    for (int i = 0; i < beats; i++)
    begin
      for (int j = 0; j < 4; j++)
        if (!ctl[5] || (!ctl[4] && !ctl[j])) exp_mem[beat_addr(a, i)][9*j +: 9] = d[9*j +: 9] ^ 9'(i);
      if (i == 0) i_host.start(1'b0, 1'b1, a, ctl, d);
      else i_host.next_beat(ctl, d ^ {4{9'(i)}});
    end
    i_host.release_bus();
    i_host.step();
  endtask

  // four-beat read: nothing at cycle 2, words on cycles 3 to 6, then idle
  task automatic rd_chk(input logic [5:0] a, input logic use_ctrl);
    i_host.start(use_ctrl, 1'b1, a, 6'h3F, 36'h0);
    i_host.next_beat(6'h3F, 36'h0);
    chk({35'h0, rd_valid}, 36'h0, "early word");
    i_host.next_beat(6'h3F, 36'h0);
    for (int i = 0; i < 4; i++)
    begin
      chk({34'h0, rd_valid, dq_oe}, 36'h3, "valid");
      chk(dq_out, exp_mem[beat_addr(a, i)], "word");
      if (i == 0) i_host.next_beat(6'h3F, 36'h0);
      else
      begin
        if (i == 1) i_host.release_bus();
        i_host.step();
      end
    end
    chk({35'h0, rd_valid}, 36'h0, "extra word");
  endtask

  // two, four, one lane and refused byte writes beside global ones
  task automatic byte_writes();
    wr_burst(6'h08, 6'h1F, 36'h1_1111_1111, 4);
    wr_burst(6'h08, 6'h2A, 36'h2_2222_2222, 1);
    wr_burst(6'h09, 6'h3E, 36'h3_3333_3333, 1);
    wr_burst(6'h0A, 6'h20, 36'h4_4444_4444, 1);
    wr_burst(6'h0B, 6'h2E, 36'h5_5555_5555, 1);
    rd_chk(6'h08, 1'b1);
    wr_burst(6'h09, 6'h0E, 36'h6_6666_6666, 1);
    rd_chk(6'h08, 1'b0);
  endtask

  // deselect strobe in mid-burst stops the drive one cycle later
  task automatic deselect_mid_read();
    i_host.start(1'b1, 1'b1, 6'h04, 6'h3F, 36'h0);
    i_host.next_beat(6'h3F, 36'h0);
    i_host.start(1'b1, 1'b0, 6'h04, 6'h3F, 36'h0);
    chk({35'h0, dq_oe}, 36'h0, "drive after deselect");
    chk(dq_out, exp_mem[6'h04], "drained word");
    // advance held low once more: an idle port must not make a beat of it
    i_host.next_beat(6'h3F, 36'h0);
    i_host.release_bus();
    repeat (2) i_host.step();
    chk({35'h0, rd_valid}, 36'h0, "beat after deselect");
  endtask

  // receiver stalls; async pins act mid-cycle; words drain in order
  task automatic stall_and_async();
    rd_ready = 1'b0;
    i_host.start(1'b0, 1'b1, 6'h08, 6'h3F, 36'h0);
    i_host.next_beat(6'h3F, 36'h0);
    i_host.next_beat(6'h3F, 36'h0);
    i_host.release_bus();
    repeat (4) i_host.step();
    chk(dq_out, exp_mem[6'h08], "held word");
    out_en_n = 1'b1;
    #2 chk({35'h0, dq_oe}, 36'h0, "oe off");
    out_en_n = 1'b0;
    #2 chk({35'h0, dq_oe}, 36'h1, "oe on");
    sleep_req = 1'b1;
    #2 chk({35'h0, dq_oe}, 36'h0, "sleep off");
    sleep_req = 1'b0;
    i_host.step();
    rd_ready = 1'b1;
    for (int i = 0; i < 3; i++)
    begin
      chk(dq_out, exp_mem[beat_addr(6'h08, i)], "drain");
      i_host.step();
    end
    chk({35'h0, rd_valid}, 36'h0, "drained");
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // 125 MHz clock
  initial
  begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  // watchdog: the whole sequence needs about 112 cycles
  initial
  begin
    repeat (3000) @(posedge sys_clk);
    mismatches++;
    report_and_stop();
  end

  // main sequence
  initial
  begin
    rst_n = 1'b0;
    out_en_n = 1'b0;
    sleep_req = 1'b0;
    linear_burst_sel = 1'b0;
    rd_ready = 1'b1;
    lin = 1'b0;
    repeat (20) @(posedge sys_clk);
    #1 rst_n = 1'b1;
    repeat (3) i_host.step();
    wr_burst(6'h05, 6'h1F, 36'hA_BCDE_F012, 4);
    rd_chk(6'h05, 1'b0);
    rd_chk(6'h06, 1'b1);
    byte_writes();
    deselect_mid_read();
    stall_and_async();
    linear_burst_sel = 1'b1;
    lin = 1'b1;
    repeat (5) i_host.step();
    wr_burst(6'h13, 6'h1F, 36'h7_0F0F_0F0F, 4);
    rd_chk(6'h13, 1'b0);
    rd_chk(6'h05, 1'b1);
    report_and_stop();
  end
endmodule // test_pipelined_sync_burst_sram_port

// [verilog/psbs_buf_if.sv]
// valid/ready word carrier between the port's own stages
interface psbs_buf_if #(parameter int W = 36);
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// [verilog/psbs_pkg.sv]
package psbs_pkg;
  // ----------------------------------------------------------------
  // array organisation of the two variants
  // ----------------------------------------------------------------
  localparam int ADDR_W_X36 = 19; // 524,288 words
  localparam int DATA_W_X36 = 36;
  localparam int ADDR_W_X18 = 20; // 1,048,576 words
  localparam int DATA_W_X18 = 18;
  localparam int BYTE_W = 9; // eight data bits plus parity per lane

  // ----------------------------------------------------------------
  // burst, pipeline and buffer figures
  // ----------------------------------------------------------------
  localparam int BURST_W = 2; // two-bit burst counter
  localparam logic [1:0] BURST_CNT_RST = 2'h0;
  localparam logic [1:0] BURST_STEP = 2'h1;
  localparam int SYNC_STAGES = 3;
  localparam logic [2:0] SYNC_RST = 3'h0;
  localparam int BUF_DEPTH = 2;
  localparam int FIRST_WORD_CYCLES = 3; // 3-1-1-1

  typedef enum logic {PSBS_IDLE, PSBS_BURST} psbs_state_e;
endpackage

// [verilog/psbs_skid.sv]
// ------------------------------------------------------------------
// small fifo holding read words while the receiver stalls
// ------------------------------------------------------------------
module psbs_skid #(
  parameter int W = 36,
  parameter int DEPTH = psbs_pkg::BUF_DEPTH
) (
  input wire logic sys_clk, // port clock
  input wire logic rst_n, // async reset, active low
  psbs_buf_if.snk up, // words from the array
  psbs_buf_if.src dn // words toward the output register
);
  localparam int PW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [PW-1:0] wp, rp, next_wp, next_rp;
  logic [PW:0] cnt, next_cnt;
  logic push, pop;

  // honest full and empty straight from the fill count
  assign up.ready = (cnt != (PW+1)'(DEPTH));
  assign dn.valid = (cnt != '0);
  assign dn.data = mem[rp];
  assign push = up.valid && up.ready;
  assign pop = dn.valid && dn.ready;

  // pointer and count updates
  always_comb
  begin
    next_wp = push ? wp + PW'(1) : wp;
    next_rp = pop ? rp + PW'(1) : rp;
    next_cnt = cnt + (PW+1)'(push) - (PW+1)'(pop);
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wp <= '0;
      rp <= '0;
      cnt <= '0;
    end
    else
    begin
      wp <= next_wp;
      rp <= next_rp;
      cnt <= next_cnt;
    end
  end

  // storage carries no reset, contents are don't-care when empty
  always_ff @(posedge sys_clk)
  begin
    if (push)
      mem[wp] <= up.data;
  end
endmodule // psbs_skid

// [verilog/psbs_sram_port.sv]
// Function
// [RL1] every synchronous input is registered on the rising clock edge
// [RL2] address and enables load only on an edge with a strobe active
// [RL3] later burst addresses come from the two-bit counter, stepped by advance
// [RL4] counter follows interleaved or linear order, chosen by the user
// [RL5] writes register address, data, controls, then finish on internal timing
// [RL6] byte selects choose one, two or all four bytes to update
// [RL7] global write low writes every byte lane
// [RL8] output enable and sleep act without the clock
// [RL9] four-beat read gives first word after three cycles, then one per cycle
// [RL10] inputs and data outputs are both registered, pipelined
// [RL11] deselect through chip enables takes effect in one cycle
// [RL12] array is 512K x 36 or 1M x 18 by variant
// [RL13] low two address bits seed the burst counter on load
// [RL14] byte write needs byte-write enable low with the byte selects
// [RL15] counter steps on each edge with advance low during a burst
// [RL16] global write updates all bytes whatever the byte controls say
// [RL17] data outputs float when deselected or output enable is high
module psbs_sram_port #(
  parameter int AW = psbs_pkg::ADDR_W_X36, // see [RL12]
  parameter int DW = psbs_pkg::DATA_W_X36 // see [RL12]
) (
  input wire logic sys_clk, // port clock, 125 MHz
  input wire logic rst_n, // async reset, active low
  input wire logic [AW-1:0] addr, // word address
  input wire logic proc_addr_strobe_n, // processor strobe
  input wire logic ctrl_addr_strobe_n, // controller strobe
  input wire logic burst_advance_n, // advance burst counter
  input wire logic pipe_chip_en_n, // chip enable, low
  input wire logic depth_chip_en_hi, // depth enable, high
  input wire logic depth_chip_en_n, // depth enable, low
  input wire logic [DW/psbs_pkg::BYTE_W-1:0] byte_lane_sel_n, // byte selects
  input wire logic byte_wr_en_n, // byte write enable
  input wire logic all_bytes_wr_n, // global write
  input wire logic out_en_n, // async output enable
  input wire logic sleep_req, // async sleep request
  input wire logic linear_burst_sel, // strap: 1 linear, 0 interleaved
  input wire logic [DW-1:0] dq_in, // data pin input
  output logic [DW-1:0] dq_out, // data pin output, registered
  output logic dq_oe, // data pin drive enable
  output logic rd_valid, // output register holds a word
  input wire logic rd_ready // receiver takes the word
);
  localparam int NB = DW / psbs_pkg::BYTE_W;
  localparam int BW = psbs_pkg::BYTE_W;

  // ----------------------------------------------------------------
  // strap and sleep synchronisers
  // ----------------------------------------------------------------
  logic [2:0] sleep_sync, mode_sync, next_sleep_sync, next_mode_sync;
  logic sleep_s, linear_s, next_sleep_s, next_linear_s;

  // a level counts once the second and third stages agree
  always_comb
  begin
    next_sleep_sync = {sleep_sync[1:0], sleep_req};
    next_mode_sync = {mode_sync[1:0], linear_burst_sel};
    next_sleep_s = (sleep_sync[2] == sleep_sync[1]) ? sleep_sync[2] : sleep_s;
    next_linear_s = (mode_sync[2] == mode_sync[1]) ? mode_sync[2] : linear_s;
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sleep_sync <= psbs_pkg::SYNC_RST;
      mode_sync <= psbs_pkg::SYNC_RST;
      sleep_s <= 1'b0;
      linear_s <= 1'b0;
    end
    else
    begin
      sleep_sync <= next_sleep_sync;
      mode_sync <= next_mode_sync;
      sleep_s <= next_sleep_s;
      linear_s <= next_linear_s;
    end
  end

  // ----------------------------------------------------------------
  // access decode and burst counter
  // ----------------------------------------------------------------
  psbs_pkg::psbs_state_e state, next_state;
  logic [AW-1:0] base, next_base;
  logic [1:0] cnt, next_cnt, step, lo;
  logic strobe, sel, load, deselect, advance, beat, stall, wr_req;
  logic [NB-1:0] be_req;
  logic [AW-1:0] beat_addr;

  // processor strobe is ignored while the pipe enable is high
  assign strobe = !ctrl_addr_strobe_n || (!proc_addr_strobe_n && !pipe_chip_en_n);
  assign sel = !pipe_chip_en_n && depth_chip_en_hi && !depth_chip_en_n;
  assign load = strobe && sel && !stall && !sleep_s; // see [RL2]
  assign deselect = strobe && !sel; // see [RL11]
  assign advance = (state == psbs_pkg::PSBS_BURST) && !strobe && !burst_advance_n && !stall && !sleep_s;
  assign beat = load || advance;
  assign step = cnt + psbs_pkg::BURST_STEP;
  // interleaved order is an xor of seed and count, linear a sum
  assign lo = linear_s ? base[1:0] + step : base[1:0] ^ step; // see [RL4]
  assign beat_addr = load ? addr : {base[AW-1:2], lo}; // see [RL3]
  // global write beats any byte control
  assign wr_req = !all_bytes_wr_n || (!byte_wr_en_n && !(&byte_lane_sel_n));
  assign be_req = !all_bytes_wr_n ? {NB{1'b1}} : (!byte_wr_en_n ? ~byte_lane_sel_n : '0); // see [RL7] [RL16] [RL14]

  // burst state, address base and counter
  always_comb
  begin
    next_state = state;
    next_base = base;
    next_cnt = cnt;
    if (deselect)
      next_state = psbs_pkg::PSBS_IDLE; // see [RL11]
    else if (load)
    begin
      next_state = psbs_pkg::PSBS_BURST;
      next_base = addr; // see [RL13]
      next_cnt = psbs_pkg::BURST_CNT_RST;
    end
    else if (advance)
      next_cnt = step; // see [RL15]
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state <= psbs_pkg::PSBS_IDLE;
      base <= '0;
      cnt <= psbs_pkg::BURST_CNT_RST;
    end
    else
    begin
      state <= next_state;
      base <= next_base;
      cnt <= next_cnt;
    end
  end

  // ----------------------------------------------------------------
  // input register stage and array
  // ----------------------------------------------------------------
  logic s1_valid, s1_wr, next_s1_valid, next_s1_wr;
  logic [AW-1:0] s1_addr, next_s1_addr;
  logic [DW-1:0] s1_data, next_s1_data;
  logic [NB-1:0] s1_be, next_s1_be;
  logic [DW-1:0] mem [2**AW];
  psbs_buf_if #(.W(DW)) bin ();
  psbs_buf_if #(.W(DW)) bout ();

  // a read that the full buffer cannot take holds the stage
  assign stall = s1_valid && !s1_wr && !bin.ready;
  assign bin.valid = s1_valid && !s1_wr;
  assign bin.data = mem[s1_addr];

  // capture of address, data and write controls on each beat
  always_comb
  begin
    next_s1_valid = s1_valid;
    next_s1_wr = s1_wr;
    next_s1_addr = s1_addr;
    next_s1_data = s1_data;
    next_s1_be = s1_be;
    if (!stall)
    begin
      next_s1_valid = beat; // see [RL1]
      next_s1_wr = wr_req;
      next_s1_addr = beat_addr;
      next_s1_data = dq_in;
      next_s1_be = be_req;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s1_valid <= 1'b0;
      s1_wr <= 1'b0;
      s1_addr <= '0;
      s1_data <= '0;
      s1_be <= '0;
    end
    else
    begin
      s1_valid <= next_s1_valid;
      s1_wr <= next_s1_wr;
      s1_addr <= next_s1_addr;
      s1_data <= next_s1_data;
      s1_be <= next_s1_be;
    end
  end

  // self-timed write one edge after capture, per byte lane
  always_ff @(posedge sys_clk)
  begin
    for (int b = 0; b < NB; b++)
    begin
      if (s1_valid && s1_wr && s1_be[b])
        mem[s1_addr][b*BW +: BW] <= s1_data[b*BW +: BW]; // see [RL5] [RL6]
    end
  end

  psbs_skid #(.W(DW), .DEPTH(psbs_pkg::BUF_DEPTH)) u_skid (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .up(bin),
    .dn(bout)
  );

  // ----------------------------------------------------------------
  // output register and pin drive
  // ----------------------------------------------------------------
  logic next_rd_valid, drive_sel, next_drive_sel;
  logic [DW-1:0] next_dq_out;

  assign bout.ready = !rd_valid || rd_ready;
  // async gating: no clock between the pins and the enable
  assign dq_oe = rd_valid && drive_sel && !out_en_n && !sleep_req; // see [RL8] [RL17]

  // output stage refills as soon as the receiver takes a word
  always_comb
  begin
    next_rd_valid = rd_valid && !rd_ready;
    next_dq_out = dq_out;
    next_drive_sel = deselect ? 1'b0 : (load ? 1'b1 : drive_sel);
    if (bout.valid && bout.ready)
    begin
      next_rd_valid = 1'b1; // see [RL9]
      next_dq_out = bout.data; // see [RL10]
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rd_valid <= 1'b0;
      dq_out <= '0;
      drive_sel <= 1'b0;
    end
    else
    begin
      rd_valid <= next_rd_valid;
      dq_out <= next_dq_out;
      drive_sel <= next_drive_sel;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  load_seed_a: assert property (load |=> state == psbs_pkg::PSBS_BURST && base[1:0] == $past(addr[1:0])
    && cnt == psbs_pkg::BURST_CNT_RST) else $error("load did not seed burst"); // see [RL13]
  deselect_a: assert property (deselect |=> state == psbs_pkg::PSBS_IDLE && !dq_oe)
    else $error("deselect not taken in one cycle"); // see [RL11]
  no_strobe_a: assert property (!strobe && state == psbs_pkg::PSBS_IDLE |=> $stable(base))
    else $error("address loaded without strobe"); // see [RL2]
  adv_step_a: assert property (advance |=> cnt == $past(cnt) + 2'h1)
    else $error("counter failed to step"); // see [RL15]
  adv_hold_a: assert property (burst_advance_n && !strobe |=> $stable(cnt))
    else $error("counter moved without advance"); // see [RL3]
  order_a: assert property (advance && !linear_s |=> s1_addr[1:0] == ($past(base[1:0]) ^ cnt))
    else $error("interleaved order wrong"); // see [RL4]
  first_word_a: assert property (beat && !wr_req && !s1_valid && !bout.valid && !rd_valid
    |-> ##3 rd_valid) else $error("first word not after three cycles"); // see [RL9]
  global_wr_a: assert property (beat && !all_bytes_wr_n |=> s1_wr && &s1_be)
    else $error("global write missed a lane"); // see [RL7]
  byte_wr_a: assert property (beat && all_bytes_wr_n && !byte_wr_en_n |=> s1_be == ~$past(byte_lane_sel_n))
    else $error("byte lanes wrong"); // see [RL14]
  float_a: assert property (out_en_n || !drive_sel |-> !dq_oe)
    else $error("pins driven while disabled"); // see [RL17]

  burst4_c: cover property (load && !wr_req ##1 advance [*3] ##3 rd_valid);
  global_c: cover property (beat && !all_bytes_wr_n);
  stall_c: cover property (stall ##1 stall);
  desel_c: cover property (rd_valid ##1 deselect);
endmodule // psbs_sram_port
